// file: src/adcs_sequencer.sv
// Behaviour
// - Clearing go mid-conversion aborts it at once
// - Aborted conversion leaves result pair untouched
// - Two bit periods wait, then acquisition resumes
// - First segment lasts one instruction cycle
// - Completion loads 10-bit result into pair
// - Justify bit aligns result, zero fill
// - Result bytes are plain storage when idle
// - Sleep conversion only with RC clock
// - RC clock delays start one instruction cycle
// - Sleep completion clears go, loads, wakes
// - Sleep completion without enable powers down
// - Sleep with non-RC clock aborts, powers down
// - Reset clears control, converter off, aborts
// - Reset leaves result pair unchanged
// - Completion clears go, sets done flag
// - Clock select gives 2/8/32 Tosc or RC
// - Conversion takes twelve bit periods
module adcs_sequencer import adcs_pkg::*; #(
   parameter int TOSC_CLKS = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_req,
   input wire logic rc_tick,
   input wire logic comp_in,
   output logic [2:0] channel_sel,
   output logic conv_power,
   output logic sample_en,
   output logic [9:0] sar_code,
   output logic wake_req
);
   localparam int INSTR_CLKS = INSTR_CYCLE_TOSC * TOSC_CLKS;

   function automatic logic hit(input logic [AXI_ADDR_W-1:0] addr, input logic [7:0] idx);
      hit = (addr[AXI_ADDR_W-1:2] == idx);
   endfunction

   function automatic logic [7:0] tad_len(input logic [1:0] sel);
      if (sel == CLKSEL_2TOSC) begin
         tad_len = 8'(TAD_MULT_2 * TOSC_CLKS);
      end else if (sel == CLKSEL_8TOSC) begin
         tad_len = 8'(TAD_MULT_8 * TOSC_CLKS);
      end else begin
         tad_len = 8'(TAD_MULT_32 * TOSC_CLKS);
      end
   endfunction

   function automatic logic [15:0] format_result(input logic right, input logic [9:0] val);
      format_result = right ? {6'h00, val} : {val, 6'h00};
   endfunction

   // Bus state
   logic aw_full;
   logic next_aw_full;
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic [AXI_ADDR_W-1:0] next_aw_addr;
   logic w_full;
   logic next_w_full;
   logic [7:0] w_data;
   logic [7:0] next_w_data;
   logic w_strb;
   logic next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic rd_pend;
   logic next_rd_pend;
   logic [AXI_ADDR_W-1:0] rd_addr;
   logic [AXI_ADDR_W-1:0] next_rd_addr;
   logic next_arready;
   logic next_rvalid;
   logic [1:0] next_rresp;
   logic [31:0] next_rdata;
   logic wr_fire;
   logic wr_mapped;
   logic [7:0] rd_value;
   logic rd_mapped;
   logic [7:0] mem_rd_data;

   // Control state
   logic [7:0] interrupt_control;
   logic [7:0] next_interrupt_control;
   logic [7:0] pir;
   logic [7:0] next_pir;
   logic [7:0] pie;
   logic [7:0] next_pie;
   logic done_flag;
   logic next_done_flag;
   logic go;
   logic next_go;
   logic enable;
   logic next_enable;
   logic [1:0] clk_sel;
   logic [1:0] next_clk_sel;
   logic [2:0] next_chan;
   logic justify;
   logic next_justify;
   logic [3:0] pcfg;
   logic [3:0] next_pcfg;
   logic powered_down;
   logic next_powered_down;
   adcs_state_t state;
   adcs_state_t next_state;
   logic [7:0] tad_cnt;
   logic [7:0] next_tad_cnt;
   logic [3:0] tad_idx;
   logic [3:0] next_tad_idx;
   logic [9:0] next_sar;
   logic [9:0] sar_res;
   logic [3:0] bitpos;
   logic next_conv_power;
   logic next_sample_en;
   logic next_wake_req;
   logic tad_tick;
   logic conv_load;
   logic [15:0] conv_value;
   logic wr_interrupt_control;
   logic wr_pir;
   logic wr_pie;
   logic wr_ctrl;
   logic wr_cfg;
   logic busy;

   assign wr_fire = aw_full && w_full && !s_axi_bvalid;
   assign wr_interrupt_control = wr_fire && w_strb && hit(aw_addr, IDX_INTERRUPT_CONTROL);
   assign wr_pir = wr_fire && w_strb && hit(aw_addr, IDX_PERIPHERAL_IRQ_FLAGS);
   assign wr_pie = wr_fire && w_strb && hit(aw_addr, IDX_PERIPHERAL_IRQ_ENABLES);
   assign wr_ctrl = wr_fire && w_strb && hit(aw_addr, IDX_CONVERTER_CONTROL);
   assign wr_cfg = wr_fire && w_strb && hit(aw_addr, IDX_CONVERTER_CONFIG);
   assign wr_mapped = hit(aw_addr, IDX_INTERRUPT_CONTROL) || hit(aw_addr, IDX_PERIPHERAL_IRQ_FLAGS)
      || hit(aw_addr, IDX_PERIPHERAL_IRQ_ENABLES) || hit(aw_addr, IDX_CONVERTER_CONTROL)
      || hit(aw_addr, IDX_CONVERTER_CONFIG) || hit(aw_addr, IDX_RESULT_HIGH)
      || hit(aw_addr, IDX_RESULT_LOW);
   // Compare with >= so a switch to a shorter period mid-count cannot overrun
   assign tad_tick = (clk_sel == CLKSEL_RC) ? rc_tick : (tad_cnt >= tad_len(clk_sel) - 8'h01);
   assign busy = (state == ADCS_START) || (state == ADCS_CONV);

   adcs_result_store u_result (
      .clk(clk),
      .sw_we_high(wr_fire && w_strb && hit(aw_addr, IDX_RESULT_HIGH)),
      .sw_we_low(wr_fire && w_strb && hit(aw_addr, IDX_RESULT_LOW)),
      .sw_wdata(w_data),
      .conv_load(conv_load),
      .conv_value(conv_value),
      .rd_low(hit(s_axi_araddr, IDX_RESULT_LOW)),
      .rd_data(mem_rd_data)
   );

   // Read data selection
   always_comb begin
      rd_mapped = 1'b1;
      if (hit(rd_addr, IDX_INTERRUPT_CONTROL)) begin
         rd_value = interrupt_control;
      end else if (hit(rd_addr, IDX_PERIPHERAL_IRQ_FLAGS)) begin
         rd_value = pir;
         rd_value[FLAG_DONE_BIT] = done_flag;
      end else if (hit(rd_addr, IDX_PERIPHERAL_IRQ_ENABLES)) begin
         rd_value = pie;
      end else if (hit(rd_addr, IDX_CONVERTER_CONTROL)) begin
         rd_value = {clk_sel, channel_sel, go, 1'b0, enable};
      end else if (hit(rd_addr, IDX_CONVERTER_CONFIG)) begin
         rd_value = {justify, 3'h0, pcfg};
      end else if (hit(rd_addr, IDX_RESULT_HIGH) || hit(rd_addr, IDX_RESULT_LOW)) begin
         rd_value = mem_rd_data;
      end else begin
         rd_value = 8'h00;
         rd_mapped = 1'b0;
      end
   end

   // AXI4-Lite slave
   always_comb begin
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full = w_full;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rd_pend = rd_pend;
      next_rd_addr = rd_addr;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_full = 1'b1;
         next_w_data = s_axi_wdata[7:0];
         next_w_strb = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rd_pend = 1'b1;
         next_rd_addr = s_axi_araddr;
      end
      if (rd_pend) begin
         next_rd_pend = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = {24'h000000, rd_value};
         next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_full && !next_bvalid;
      next_wready = !next_w_full && !next_bvalid;
      next_arready = !next_rd_pend && !next_rvalid;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
         w_full <= 1'b0;
         w_data <= 8'h00;
         w_strb <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         rd_pend <= 1'b0;
         rd_addr <= '0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else begin
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full <= next_w_full;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         rd_pend <= next_rd_pend;
         rd_addr <= next_rd_addr;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end

   // Conversion sequencing and control registers
   always_comb begin
      next_interrupt_control = interrupt_control;
      next_pir = pir;
      next_pie = pie;
      next_done_flag = done_flag;
      next_go = go;
      next_enable = enable;
      next_clk_sel = clk_sel;
      next_chan = channel_sel;
      next_justify = justify;
      next_pcfg = pcfg;
      next_powered_down = powered_down;
      next_state = state;
      next_tad_cnt = tad_tick ? 8'h00 : tad_cnt + 8'h01;
      next_tad_idx = tad_idx;
      next_sar = sar_code;
      conv_load = 1'b0;
      conv_value = 16'h0000;
      bitpos = CONV_TADS - 4'h1 - tad_idx;
      sar_res = sar_code;
      if (wr_interrupt_control) begin
         next_interrupt_control = w_data;
      end
      if (wr_pir) begin
         next_pir = w_data & PIR_STORE_MASK;
         next_done_flag = w_data[FLAG_DONE_BIT];
      end
      if (wr_pie) begin
         next_pie = w_data & PIE_STORE_MASK;
      end
      if (wr_cfg) begin
         next_justify = w_data[CFG_JUSTIFY_BIT];
         next_pcfg = w_data[CFG_PCFG_LSB +: 4];
      end
      if (wr_ctrl) begin
         next_clk_sel = w_data[CTRL_CLKSEL_LSB +: 2];
         next_chan = w_data[CTRL_CHAN_LSB +: 3];
         next_enable = w_data[CTRL_ENABLE_BIT];
         next_go = w_data[CTRL_GO_BIT] && enable && w_data[CTRL_ENABLE_BIT];
      end
      if (!sleep_req) begin
         next_powered_down = 1'b0;
      end else if (next_enable && (next_clk_sel != CLKSEL_RC)) begin
         next_powered_down = 1'b1;
         next_go = 1'b0;
      end
      case (state)
         ADCS_ACQUIRE: begin
            next_tad_cnt = 8'h00;
            if (go && enable && !powered_down && !next_powered_down) begin
               next_state = ADCS_START;
            end
         end
         ADCS_START: begin
            next_tad_cnt = tad_cnt + 8'h01;
            if (tad_cnt == 8'(INSTR_CLKS - 1)) begin
               next_state = ADCS_CONV;
               next_tad_cnt = 8'h00;
               next_tad_idx = 4'h0;
               next_sar = 10'h000;
            end
         end
         ADCS_CONV: begin
            if (tad_tick) begin
               next_tad_idx = tad_idx + 4'h1;
               if (tad_idx == 4'h1) begin
                  next_sar = 10'h200;
               end else if (tad_idx > 4'h1) begin
                  if (!comp_in) begin
                     sar_res[bitpos] = 1'b0;
                  end
                  if (bitpos != 4'h0) begin
                     sar_res[bitpos - 4'h1] = 1'b1;
                  end
                  next_sar = sar_res;
               end
               if (tad_idx == CONV_TADS - 4'h1) begin
                  conv_load = 1'b1;
                  conv_value = format_result(justify, sar_res);
                  next_go = 1'b0;
                  next_done_flag = 1'b1;
                  if (sleep_req && !pie[FLAG_DONE_BIT]) begin
                     next_powered_down = 1'b1;
                  end
                  next_state = ADCS_DISCH;
                  next_tad_idx = 4'h0;
                  next_tad_cnt = 8'h00;
               end
            end
         end
         ADCS_DISCH: begin
            if (tad_tick) begin
               next_tad_idx = tad_idx + 4'h1;
               if (tad_idx == DISCH_TADS - 4'h1) begin
                  next_state = ADCS_ACQUIRE;
               end
            end
         end
         default: begin
            next_state = ADCS_ACQUIRE;
         end
      endcase
      if (busy && !next_go && !conv_load) begin
         next_state = ADCS_DISCH;
         next_tad_idx = 4'h0;
         next_tad_cnt = 8'h00;
      end
      if (!next_enable) begin
         next_go = 1'b0;
         next_state = ADCS_ACQUIRE;
      end
      next_conv_power = next_enable && !next_powered_down;
      next_sample_en = next_conv_power && (next_state == ADCS_ACQUIRE);
      next_wake_req = next_done_flag && next_pie[FLAG_DONE_BIT];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_control <= RST_INTERRUPT_CONTROL;
         pir <= RST_PERIPHERAL_IRQ_FLAGS;
         pie <= RST_PERIPHERAL_IRQ_ENABLES;
         done_flag <= RST_PERIPHERAL_IRQ_FLAGS[FLAG_DONE_BIT];
         go <= RST_CONVERTER_CONTROL[CTRL_GO_BIT];
         enable <= RST_CONVERTER_CONTROL[CTRL_ENABLE_BIT];
         clk_sel <= RST_CONVERTER_CONTROL[CTRL_CLKSEL_LSB +: 2];
         channel_sel <= RST_CONVERTER_CONTROL[CTRL_CHAN_LSB +: 3];
         justify <= RST_CONVERTER_CONFIG[CFG_JUSTIFY_BIT];
         pcfg <= RST_CONVERTER_CONFIG[CFG_PCFG_LSB +: 4];
         powered_down <= 1'b0;
         state <= ADCS_ACQUIRE;
         tad_cnt <= 8'h00;
         tad_idx <= 4'h0;
         sar_code <= 10'h000;
         conv_power <= 1'b0;
         sample_en <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         interrupt_control <= next_interrupt_control;
         pir <= next_pir;
         pie <= next_pie;
         done_flag <= next_done_flag;
         go <= next_go;
         enable <= next_enable;
         clk_sel <= next_clk_sel;
         channel_sel <= next_chan;
         justify <= next_justify;
         pcfg <= next_pcfg;
         powered_down <= next_powered_down;
         state <= next_state;
         tad_cnt <= next_tad_cnt;
         tad_idx <= next_tad_idx;
         sar_code <= next_sar;
         conv_power <= next_conv_power;
         sample_en <= next_sample_en;
         wake_req <= next_wake_req;
      end
   end
endmodule

// file: src/adcs_pkg.sv
package adcs_pkg;
   localparam int AXI_ADDR_W = 10;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
   localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
   localparam logic [7:0] IDX_CONVERTER_CONTROL = 8'h1F;
   localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_RESULT_LOW = 8'h9E;
   localparam logic [7:0] IDX_CONVERTER_CONFIG = 8'h9F;
   // Reset values
   localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
   localparam logic [7:0] RST_CONVERTER_CONFIG = 8'h00;
   // Field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_GO_BIT = 2;
   localparam int CTRL_CHAN_LSB = 3;
   localparam int CTRL_CLKSEL_LSB = 6;
   localparam int CFG_JUSTIFY_BIT = 7;
   localparam int CFG_PCFG_LSB = 0;
   localparam int FLAG_DONE_BIT = 6;
   localparam logic [7:0] PIR_STORE_MASK = 8'hB7;
   localparam logic [7:0] PIE_STORE_MASK = 8'hF7;
   // Conversion clock select codes
   localparam logic [1:0] CLKSEL_2TOSC = 2'h0;
   localparam logic [1:0] CLKSEL_8TOSC = 2'h1;
   localparam logic [1:0] CLKSEL_32TOSC = 2'h2;
   localparam logic [1:0] CLKSEL_RC = 2'h3;
   // Timing, in oscillator periods or conversion-bit periods
   localparam int TAD_MULT_2 = 2;
   localparam int TAD_MULT_8 = 8;
   localparam int TAD_MULT_32 = 32;
   localparam int INSTR_CYCLE_TOSC = 4;
   localparam logic [3:0] CONV_TADS = 4'hC;
   localparam logic [3:0] DISCH_TADS = 4'h2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ADCS_ACQUIRE,
      ADCS_START,
      ADCS_CONV,
      ADCS_DISCH
   } adcs_state_t;
endpackage

// file: src/adcs_result_store.sv
module adcs_result_store import adcs_pkg::*; (
   input wire logic clk,
   input wire logic sw_we_high,
   input wire logic sw_we_low,
   input wire logic [7:0] sw_wdata,
   input wire logic conv_load,
   input wire logic [15:0] conv_value,
   input wire logic rd_low,
   output logic [7:0] rd_data
);
   logic [7:0] high;
   logic [7:0] low;
   logic [7:0] next_high;
   logic [7:0] next_low;
   logic [7:0] next_rd_data;

   // Result load wins over a software write in the same cycle
   always_comb begin
      next_high = high;
      next_low = low;
      if (conv_load) begin
         next_high = conv_value[15:8];
         next_low = conv_value[7:0];
      end else begin
         if (sw_we_high) begin
            next_high = sw_wdata;
         end
         if (sw_we_low) begin
            next_low = sw_wdata;
         end
      end
      next_rd_data = rd_low ? low : high;
   end

   // No reset: content survives any reset
   always_ff @(posedge clk) begin
      high <= next_high;
      low <= next_low;
      rd_data <= next_rd_data;
   end
endmodule

// file: bench/adcs_analog_model.sv
module adcs_analog_model #(
   parameter int RC_DIV = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [9:0] level,
   input wire logic [9:0] sar_code,
   output logic comp_in,
   output logic rc_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Comparator keeps the trial bit while the input reaches the trial code
   assign comp_in = (level >= sar_code);
   // Free-running RC bit clock, one pulse per period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         rc_tick <= 1'h0;
      end else begin
         cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
         rc_tick <= (cnt == RC_DIV - 1);
      end
   end
endmodule

// file: bench/adcs_sequencer_monitor.sv
module adcs_sequencer_monitor import adcs_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_req,
   input wire logic conv_power,
   input wire logic sample_en,
   input wire logic wake_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
      return a[AXI_ADDR_W-1:2] inside {IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS,
         IDX_RESULT_HIGH, IDX_CONVERTER_CONTROL, IDX_PERIPHERAL_IRQ_ENABLES,
         IDX_RESULT_LOW, IDX_CONVERTER_CONFIG};
   endfunction
   a_reset_idle: assert property ($rose(rst_n) |-> !conv_power && !sample_en && !wake_req)
      else $error("outputs active after reset");
   a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 !s_axi_rvalid ##1
      (s_axi_rvalid && s_axi_rresp == (mapped($past(s_axi_araddr, 2)) ? RESP_OKAY : RESP_SLVERR)))
      else $error("read answer wrong");
   a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
   a_r_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready while response pending");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1
      (s_axi_awready && s_axi_wready)) else $error("write channel not released");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
      else $error("read channel not released");
   a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_sleep_hold: assert property (sleep_req && !conv_power |=> !conv_power || !sleep_req)
      else $error("converter powered during sleep");
   a_sleep_quiet: assert property ($fell(conv_power) && sleep_req |-> !wake_req)
      else $error("power down while waking");
   c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   c_wake: cover property ($rose(wake_req));
   c_sleep_off: cover property ($fell(conv_power) && sleep_req);
endmodule
bind adcs_sequencer adcs_sequencer_monitor i_mon (.*);

// file: bench/adcs_sequencer_bench.sv
module adcs_sequencer_bench import adcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sleep_req = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rc_tick, comp_in, conv_power, sample_en, wake_req;
   logic [2:0] channel_sel;
   logic [9:0] sar_code, level = 10'h000;
   logic [7:0] rq, eh, el;
   logic [7:0] ridx [5] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS,
      IDX_CONVERTER_CONTROL, IDX_PERIPHERAL_IRQ_ENABLES, IDX_CONVERTER_CONFIG};
   logic [7:0] rmask [5] = '{8'hFF, 8'hF7, 8'hF9, 8'hF7, 8'h8F};
   int err_total = 0, n_tests = 0, cyc = 0;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   adcs_sequencer #(.TOSC_CLKS(1)) i_dut (.*);
   adcs_analog_model i_far (.*);
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      if (we) begin
         s_axi_awaddr <= {idx, 2'h0};
         s_axi_wdata <= {24'h000000, d};
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
      end else begin
         s_axi_araddr <= {idx, 2'h0};
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
      end
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (we ? s_axi_bvalid : s_axi_rvalid) break;
      end
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
      rq = s_axi_rdata[7:0];
      rr = we ? s_axi_bresp : s_axi_rresp;
      if (n == 40) begin
         err_total++;
         end_sim;
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'h1, idx, d);
      chk(rr, RESP_OKAY);
   endtask
   task automatic rd(input logic [7:0] idx);
      xfer(1'h0, idx, 8'h00);
   endtask
   task automatic wait_for(input int k, input int lim, output int dt);
      for (dt = 0; dt < lim; dt++) begin
         @(posedge clk);
         if (k == 0 ? wake_req : (k == 1 ? !conv_power : sample_en)) break;
      end
      if (dt == lim) begin
         err_total++;
         end_sim;
      end
   endtask
   function automatic logic [15:0] just(input logic [9:0] r, input logic right);
      return right ? {6'h00, r} : {r, 6'h00};
   endfunction
   task automatic chk_res;
      rd(IDX_RESULT_HIGH);
      chk(rq, eh);
      rd(IDX_RESULT_LOW);
      chk(rq, el);
   endtask
   task automatic start(input logic [1:0] cs, input logic [2:0] ch);
      wr(IDX_CONVERTER_CONTROL, {cs, ch, 3'h1});
      wr(IDX_CONVERTER_CONTROL, {cs, ch, 3'h5});
   endtask
   task automatic rst_chk;
      for (int k = 0; k < 5; k++) begin
         rd(ridx[k]);
         chk(rq, 8'h00);
      end
   endtask
   task automatic slp(input logic ie);
      int dt;
      wr(IDX_PERIPHERAL_IRQ_ENABLES, {1'h0, ie, 6'h00});
      wr(IDX_CONVERTER_CONFIG, 8'h80);
      level <= 10'($urandom);
      start(CLKSEL_RC, 3'h2);
      sleep_req <= 1'h1;
      wait_for(ie ? 0 : 1, 400, dt);
      chk({wake_req, conv_power}, {ie, ie});
      rd(IDX_CONVERTER_CONTROL);
      chk(rq, {CLKSEL_RC, 3'h2, 3'h1});
      sleep_req <= 1'h0;
      {eh, el} = just(level, 1'h1);
      chk_res;
      wr(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
      $display("sleep conversion done");
   endtask
   initial begin
      int i, n, dt, t0;
      logic [1:0] cs;
      logic [2:0] ch;
      logic j;
      void'($urandom(11));
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      rst_chk;
      xfer(1'h0, 8'h10, 8'h00);
      chk({rr, rq}, {RESP_SLVERR, 8'h00});
      xfer(1'h1, 8'h10, 8'h55);
      chk(rr, RESP_SLVERR);
      for (i = 0; i < 5; i++) begin
         wr(ridx[i], 8'hFF);
         rd(ridx[i]);
         chk(rq, rmask[i]);
         wr(ridx[i], 8'h00);
      end
      wr(IDX_CONVERTER_CONTROL, 8'h04);
      rd(IDX_CONVERTER_CONTROL);
      chk(rq, 8'h00);
      $display("register map done");
      eh = 8'($urandom);
      el = 8'($urandom);
      wr(IDX_RESULT_HIGH, eh);
      wr(IDX_RESULT_LOW, el);
      chk_res;
      for (i = 0; i < 6; i++) begin
         cs = 2'(i % 3);
         ch = 3'($urandom);
         j = 1'($urandom);
         level <= 10'($urandom);
         wr(IDX_CONVERTER_CONFIG, {j, 7'h00});
         start(cs, ch);
         t0 = cyc;
         for (n = 0; n < 100; n++) begin
            rd(IDX_CONVERTER_CONTROL);
            if (rq[CTRL_GO_BIT] == 1'h0) break;
         end
         chk(rq[CTRL_GO_BIT], 1'h0);
         chk(cyc - t0 >= (24 << (2 * cs)), 1'h1);
         chk(channel_sel, ch);
         {eh, el} = just(level, j);
         chk_res;
         rd(IDX_PERIPHERAL_IRQ_FLAGS);
         chk(rq[FLAG_DONE_BIT], 1'h1);
         wr(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
      end
      $display("conversions done");
      slp(1'h1);
      slp(1'h0);
      eh = 8'hA5;
      el = 8'h5A;
      wr(IDX_RESULT_HIGH, eh);
      wr(IDX_RESULT_LOW, el);
      start(CLKSEL_32TOSC, 3'h5);
      sleep_req <= 1'h1;
      wait_for(1, 10, dt);
      rd(IDX_CONVERTER_CONTROL);
      chk(rq, {CLKSEL_32TOSC, 3'h5, 3'h1});
      sleep_req <= 1'h0;
      chk_res;
      $display("sleep abort done");
      wait_for(2, 100, dt);
      start(CLKSEL_32TOSC, 3'h6);
      repeat (20) @(posedge clk);
      wr(IDX_CONVERTER_CONTROL, {CLKSEL_32TOSC, 3'h6, 3'h1});
      wait_for(2, 100, dt);
      chk(dt >= 33 && dt <= 72, 1'h1);
      chk(channel_sel, 3'h6);
      rd(IDX_CONVERTER_CONTROL);
      chk(rq[CTRL_GO_BIT], 1'h0);
      chk_res;
      $display("abort done");
      start(CLKSEL_32TOSC, 3'h1);
      repeat (30) @(posedge clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      chk(conv_power, 1'h0);
      rst_chk;
      chk_res;
      $display("reset done");
      end_sim;
   end
endmodule
